// File: rtl/pmic_regs_pkg.sv
// register slice constants: offsets, field positions, reset values, key and selector codes
// assumes byte-wide registers reached through the serial target port
package pmic_regs_pkg;
	localparam logic [7:0] analog_monitor_select_ofs = 8'h09;
	localparam logic [7:0] supply_and_button_status_ofs = 8'h0A;
	localparam logic [7:0] write_unlock_key_ofs = 8'h0B;
	localparam logic [7:0] rail_good_flags_ofs = 8'h0C;
	localparam logic [7:0] first_protected_ofs = 8'h0D;
	localparam logic [7:0] analog_monitor_select_rst = 8'h00;
	localparam logic [7:0] write_unlock_key_rst = 8'h00;
	localparam logic [7:0] unlock_key_value = 8'h7D;
	localparam int off_request_bit = 7;
	localparam int adapter_present_bit = 3;
	localparam int usb_supply_present_bit = 2;
	localparam int button_active_bit = 0;
	localparam int reg3_good_bit = 6;
	localparam int reg4_good_bit = 5;
	localparam int buck1_good_bit = 4;
	localparam int buck2_good_bit = 3;
	localparam int buck3_good_bit = 2;
	localparam int linear1_good_bit = 1;
	localparam int linear2_good_bit = 0;
	localparam int sel_width = 3;
	localparam logic [2:0] sel_battery = 3'h1;
	localparam logic [2:0] sel_system_rail = 3'h2;
	localparam logic [2:0] sel_thermistor = 3'h3;
	localparam logic [2:0] sel_charge_current = 3'h4;
	localparam logic [2:0] sel_external = 3'h5;
	localparam int monitor_sources = 5;
	localparam logic [6:0] target_addr_default = 7'h10;
endpackage : pmic_regs_pkg

// File: rtl/reg_bus_if.sv
// register access signals between the serial target engine and the register slice
// assumes both ends on sys_clk; rdata is combinational from the slice
`timescale 1ns/1ps
interface reg_bus_if;
	logic wr_stb;
	logic rd_stb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic txn_end;
	modport target (output wr_stb, output rd_stb, output addr, output wdata, output txn_end, input rdata);
	modport regs (input wr_stb, input rd_stb, input addr, input wdata, input txn_end, output rdata);
endinterface : reg_bus_if

// File: rtl/serial_target.sv
// two-wire serial target engine: address match, register pointer, byte writes and reads
// assumes scl and sda_in come straight from pins; sda is open drain, sda_oe_n low pulls low
`timescale 1ns/1ps
module serial_target #(
	parameter logic [6:0] target_addr = pmic_regs_pkg::target_addr_default
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_oe_n,
	reg_bus_if.target bus
);
	import pmic_regs_pkg::*;

	typedef enum logic [6:0] {
		st_idle = 7'h01,
		st_addr = 7'h02,
		st_ack = 7'h04,
		st_reg = 7'h08,
		st_wdata = 7'h10,
		st_rdata = 7'h20,
		st_rack = 7'h40
	} state_t;

	state_t state;
	state_t after_ack;
	logic [2:0] scl_s;
	logic [2:0] sda_s;
	logic [7:0] shreg;
	logic [3:0] bitcnt;
	logic [7:0] pointer;
	logic active;
	logic pull_low;
	logic master_ack;

	// stage 0 feeds only stage 1; edges are taken between stages 1 and 2
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
		end else begin
			scl_s <= {scl_s[1:0], scl};
			sda_s <= {sda_s[1:0], sda_in};
		end
	end

	wire scl_rise = scl_s[1] & ~scl_s[2];
	wire scl_fall = ~scl_s[1] & scl_s[2];
	wire start_cond = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
	wire stop_cond = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

	assign sda_oe_n = ~pull_low;
	assign bus.addr = pointer;
	assign bus.wdata = shreg;
	assign bus.wr_stb = scl_fall && state == st_wdata && bitcnt == 4'h8;
	assign bus.rd_stb = scl_fall && ((state == st_ack && after_ack == st_rdata) || (state == st_rack && master_ack));

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bus.txn_end <= 1'b0;
			active <= 1'b0;
		end else begin
			bus.txn_end <= 1'b0;
			if (start_cond) begin
				// a repeated start also closes the previous transaction
				bus.txn_end <= active;
				active <= 1'b1;
			end else if (stop_cond) begin
				bus.txn_end <= active;
				active <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= st_idle;
			after_ack <= st_idle;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			pointer <= 8'h00;
			pull_low <= 1'b0;
			master_ack <= 1'b0;
		end else if (start_cond) begin
			state <= st_addr;
			bitcnt <= 4'h0;
			pull_low <= 1'b0;
		end else if (stop_cond) begin
			state <= st_idle;
			pull_low <= 1'b0;
		end else if (scl_rise) begin
			case (state)
				st_addr, st_reg, st_wdata: begin
					shreg <= {shreg[6:0], sda_s[1]};
					bitcnt <= bitcnt + 4'h1;
				end
				st_rdata: begin
					bitcnt <= bitcnt + 4'h1;
				end
				st_rack: begin
					master_ack <= ~sda_s[1];
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state)
				st_addr: begin
					if (bitcnt == 4'h8) begin
						if (shreg[7:1] == target_addr) begin
							pull_low <= 1'b1;
							after_ack <= shreg[0] ? st_rdata : st_reg;
							state <= st_ack;
						end else begin
							state <= st_idle;
						end
					end
				end
				st_reg: begin
					if (bitcnt == 4'h8) begin
						pointer <= shreg;
						pull_low <= 1'b1;
						after_ack <= st_wdata;
						state <= st_ack;
					end
				end
				st_wdata: begin
					if (bitcnt == 4'h8) begin
						pointer <= pointer + 8'h01;
						pull_low <= 1'b1;
						after_ack <= st_wdata;
						state <= st_ack;
					end
				end
				st_ack: begin
					bitcnt <= 4'h0;
					state <= after_ack;
					if (after_ack == st_rdata) begin
						shreg <= {bus.rdata[6:0], 1'b0};
						pull_low <= ~bus.rdata[7];
						pointer <= pointer + 8'h01;
					end else begin
						pull_low <= 1'b0;
					end
				end
				st_rdata: begin
					if (bitcnt == 4'h8) begin
						pull_low <= 1'b0;
						state <= st_rack;
					end else begin
						pull_low <= ~shreg[7];
						shreg <= {shreg[6:0], 1'b0};
					end
				end
				st_rack: begin
					bitcnt <= 4'h0;
					if (master_ack) begin
						shreg <= {bus.rdata[6:0], 1'b0};
						pull_low <= ~bus.rdata[7];
						pointer <= pointer + 8'h01;
						state <= st_rdata;
					end else begin
						state <= st_idle;
					end
				end
				default: begin
				end
			endcase
		end
	end
endmodule : serial_target

// File: rtl/pmic_status_unlock_regs.sv
// register slice 0x09..0x0C: monitor selector, status, write unlock key, rail good flags
// assumes status and rail inputs arrive asynchronously from analog comparators
//
// Summary of operation
// R1: selector codes 1..5 route battery, system rail, thermistor, charge current, external input.
// R2: selector codes 0, 6 and 7 disable the monitor mux, output floating.
// R3: writing 1 to status bit 7 enters off state once power hold is low.
// R4: the shutdown request bit clears itself once acted upon.
// R5: status bit 3 shows adapter supply present and valid.
// R6: status bit 2 shows USB supply present and valid.
// R7: status bit 0 reads 1 while the button pin is low.
// R8: key 0x7D in the unlock register permits exactly one protected write.
// R9: any other unlock value keeps protected registers locked.
// R10: unlock register clears after the next transaction following the key write completes.
// R11: buck good flags bits 4..2 read 1 only while regulating.
// R12: linear good flags bits 1..0 read 1 only while regulating.
// R13: bits 6 and 5 also read 1 when that output is a load switch.
// R14: register 0x0D and above accept writes only directly after the key.
// R15: host writes to read-only flag bits are ignored.
`timescale 1ns/1ps
module pmic_status_unlock_regs #(
	parameter logic [6:0] target_addr = pmic_regs_pkg::target_addr_default
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic power_hold_pin,
	input wire logic adapter_present,
	input wire logic usb_supply_present,
	input wire logic button_input_pin,
	input wire logic buck1_good,
	input wire logic buck2_good,
	input wire logic buck3_good,
	input wire logic linear1_good,
	input wire logic linear2_good,
	input wire logic reg3_good,
	input wire logic reg4_good,
	input wire logic reg3_is_switch,
	input wire logic reg4_is_switch,
	output logic monitor_enable,
	output logic [pmic_regs_pkg::monitor_sources-1:0] monitor_route,
	output logic off_state,
	output logic protected_wr_stb,
	output logic [7:0] protected_addr,
	output logic [7:0] protected_wdata,
	input wire logic [7:0] protected_rdata
);
	import pmic_regs_pkg::*;

	localparam int n_pins = 11;

	reg_bus_if bus ();

	logic [7:0] analog_monitor_select;
	logic [7:0] write_unlock_key;
	logic off_request;
	logic key_this_txn;
	logic [n_pins-1:0] pin_meta;
	logic [n_pins-1:0] pin_sync;
	logic [7:0] status_view;
	logic [7:0] good_view;
	logic unlocked;
	logic [7:0] read_mux;

	serial_target #(
		.target_addr(target_addr)
	) u_target (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.scl(scl),
		.sda_in(sda_in),
		.sda_oe_n(sda_oe_n),
		.bus(bus)
	);

	// open drain: the line is only ever pulled low
	assign sda_out = 1'b0;

	// comparator outputs are asynchronous, two flops before any use
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {power_hold_pin, adapter_present, usb_supply_present, ~button_input_pin,
				buck1_good, buck2_good, buck3_good, linear1_good, linear2_good,
				reg3_good | reg3_is_switch, reg4_good | reg4_is_switch};
			pin_sync <= pin_meta;
		end
	end

	wire hold_low = ~pin_sync[10];

	always_comb begin
		status_view = 8'h00;
		status_view[off_request_bit] = off_request;
		status_view[adapter_present_bit] = pin_sync[9]; // R5
		status_view[usb_supply_present_bit] = pin_sync[8]; // R6
		status_view[button_active_bit] = pin_sync[7]; // R7
	end

	always_comb begin
		good_view = 8'h00;
		good_view[buck1_good_bit] = pin_sync[6]; // R11
		good_view[buck2_good_bit] = pin_sync[5]; // R11
		good_view[buck3_good_bit] = pin_sync[4]; // R11
		good_view[linear1_good_bit] = pin_sync[3]; // R12
		good_view[linear2_good_bit] = pin_sync[2]; // R12
		good_view[reg3_good_bit] = pin_sync[1]; // R13
		good_view[reg4_good_bit] = pin_sync[0]; // R13
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			analog_monitor_select <= analog_monitor_select_rst;
		end else if (bus.wr_stb && bus.addr == analog_monitor_select_ofs) begin
			analog_monitor_select <= bus.wdata;
		end
	end

	// only the selector field steers the mux; upper bits are plain storage
	wire [sel_width-1:0] sel = analog_monitor_select[sel_width-1:0];

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			monitor_route <= '0;
			monitor_enable <= 1'b0;
		end else begin
			monitor_route <= '0;
			monitor_enable <= 1'b1;
			if (sel == sel_battery) begin
				monitor_route[0] <= 1'b1; // R1
			end else if (sel == sel_system_rail) begin
				monitor_route[1] <= 1'b1; // R1
			end else if (sel == sel_thermistor) begin
				monitor_route[2] <= 1'b1; // R1
			end else if (sel == sel_charge_current) begin
				monitor_route[3] <= 1'b1; // R1
			end else if (sel == sel_external) begin
				monitor_route[4] <= 1'b1; // R1
			end else begin
				monitor_enable <= 1'b0; // R2
			end
		end
	end

	// request stays armed until power hold falls; writing 0 does not cancel it
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			off_request <= 1'b0;
			off_state <= 1'b0;
		end else begin
			if (off_request && hold_low) begin
				off_state <= 1'b1; // R3
				off_request <= 1'b0; // R4
			end else if (bus.wr_stb && bus.addr == supply_and_button_status_ofs
				&& bus.wdata[off_request_bit]) begin
				off_request <= 1'b1; // R3
			end
		end
	end

	assign unlocked = write_unlock_key == unlock_key_value; // R9

	wire prot_write = bus.wr_stb && bus.addr >= first_protected_ofs;

	// the key survives the end of its own transaction and dies at the end of the next one
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			write_unlock_key <= write_unlock_key_rst;
			key_this_txn <= 1'b0;
		end else begin
			if (bus.wr_stb && bus.addr == write_unlock_key_ofs) begin
				write_unlock_key <= bus.wdata;
				key_this_txn <= 1'b1;
			end else if (prot_write && unlocked) begin
				write_unlock_key <= write_unlock_key_rst; // R8
			end else if (bus.txn_end) begin
				key_this_txn <= 1'b0;
				if (!key_this_txn) begin
					write_unlock_key <= write_unlock_key_rst; // R10
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			protected_wr_stb <= 1'b0;
			protected_addr <= 8'h00;
			protected_wdata <= 8'h00;
		end else begin
			protected_wr_stb <= prot_write && unlocked; // R14
			if (prot_write && unlocked) begin
				protected_addr <= bus.addr; // R8
				protected_wdata <= bus.wdata;
			end
		end
	end

	// flag bits have no write path, so host data never reaches them
	always_comb begin
		if (bus.addr == analog_monitor_select_ofs) begin
			read_mux = analog_monitor_select;
		end else if (bus.addr == supply_and_button_status_ofs) begin
			read_mux = status_view; // R15
		end else if (bus.addr == write_unlock_key_ofs) begin
			read_mux = write_unlock_key;
		end else if (bus.addr == rail_good_flags_ofs) begin
			read_mux = good_view; // R15
		end else if (bus.addr >= first_protected_ofs) begin
			read_mux = protected_rdata;
		end else begin
			read_mux = 8'h00;
		end
	end

	assign bus.rdata = read_mux;
endmodule : pmic_status_unlock_regs

// File: tb/pmic_chk.sv
// pin checks: monitor mux, shutdown latch, protected write strobe, sda timing
// assumes sys_clk only, synchronous active-low rst_n
`timescale 1ns/1ps
module pmic_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_oe_n,
	input wire logic power_hold_pin,
	input wire logic monitor_enable,
	input wire logic [pmic_regs_pkg::monitor_sources-1:0] monitor_route,
	input wire logic off_state,
	input wire logic protected_wr_stb,
	input wire logic [7:0] protected_addr,
	input wire logic [7:0] protected_wdata
);
	import pmic_regs_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_route_onehot: assert property (monitor_enable |-> $onehot(monitor_route))
		else $error("route not one-hot");
	a_disabled_route: assert property (!monitor_enable |-> monitor_route == '0)
		else $error("route set while disabled");
	a_off_hold_low: assert property ($rose(off_state) |-> !$past(power_hold_pin))
		else $error("off without hold low");
	a_off_sticky: assert property (off_state |=> off_state)
		else $error("off state dropped");
	a_strobe_pulse: assert property (protected_wr_stb |=> !protected_wr_stb)
		else $error("strobe longer than one cycle");
	a_strobe_range: assert property (protected_wr_stb |-> protected_addr >= 8'h0D)
		else $error("strobe below protected range");
	a_strobe_hold: assert property (!protected_wr_stb |-> $stable(protected_addr) && $stable(protected_wdata))
		else $error("protected bus moved");
	// sda may only move while scl is low
	a_sda_steady: assert property (scl && $past(scl) && $past(scl, 2) && $past(scl, 3) |-> $stable(sda_oe_n))
		else $error("sda moved with scl high");
endmodule : pmic_chk

bind pmic_status_unlock_regs pmic_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sda_oe_n(sda_oe_n),
	.power_hold_pin(power_hold_pin), .monitor_enable(monitor_enable), .monitor_route(monitor_route),
	.off_state(off_state), .protected_wr_stb(protected_wr_stb), .protected_addr(protected_addr),
	.protected_wdata(protected_wdata));

// File: tb/i2c_host.sv
// serial bus controller model driving the slice target port
// assumes open-drain sda with pull-up, wire level fed back on sda_w
`timescale 1ns/1ps
module i2c_host #(
	parameter logic [6:0] target_addr = pmic_regs_pkg::target_addr_default
) (
	input wire logic sys_clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda_h,
	output logic rd_done,
	output logic [7:0] rd_byte
);
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
		rd_done = 1'b0;
		rd_byte = 8'h00;
	end
	task automatic hc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : hc
	// 8 clocks a phase, twice the target minimum; sending 1 releases the wire
	task automatic clk_bit(input logic b, output logic s);
		sda_h <= b;
		hc(8);
		scl <= 1'b1;
		hc(4);
		s = sda_w;
		hc(4);
		scl <= 1'b0;
		hc(2);
	endtask : clk_bit
	task automatic start();
		sda_h <= 1'b1;
		hc(8);
		scl <= 1'b1;
		hc(8);
		sda_h <= 1'b0;
		hc(8);
		scl <= 1'b0;
		hc(2);
	endtask : start
	task automatic stop();
		sda_h <= 1'b0;
		hc(8);
		scl <= 1'b1;
		hc(8);
		sda_h <= 1'b1;
		hc(8);
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], s);
			q[i] = s;
		end
		clk_bit(m, s);
		a = !s;
	endtask : xfer
	task automatic wr(input logic [7:0] ra, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic a0, a1, a2;
		start();
		xfer({target_addr, 1'b0}, 1'b1, q, a0);
		xfer(ra, 1'b1, q, a1);
		xfer(d, 1'b1, q, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask : wr
	// n bytes in one burst: every byte but the last is acknowledged
	task automatic rd(input logic [7:0] ra, input int n);
		logic [7:0] q;
		logic a;
		start();
		xfer({target_addr, 1'b0}, 1'b1, q, a);
		xfer(ra, 1'b1, q, a);
		start();
		xfer({target_addr, 1'b1}, 1'b1, q, a);
		for (int k = 1; k <= n; k++) begin
			xfer(8'hFF, k == n, q, a);
			rd_byte <= q;
			rd_done <= 1'b1;
			hc(1);
			rd_done <= 1'b0;
		end
		stop();
	endtask : rd
endmodule : i2c_host

// File: tb/tb.sv
// self-checking bench for the register slice through its serial port
// assumes the controller model above; reads are checked from a queue of notes
`timescale 1ns/1ps
module tb;
	import pmic_regs_pkg::*;
	logic sys_clk, rst_n, scl, sda_h, sda_out, sda_oe_n, power_hold_pin, rd_done, stb, en, off, ok;
	logic [11:0] fl;
	logic [4:0] route;
	logic [7:0] pa, pd, prot_rdata, rd_byte, d, r;
	logic [7:0] stb_a = 8'h00;
	logic [7:0] stb_d = 8'h00;
	logic [7:0] q[$];
	logic [7:0] bad[5] = '{8'h00, 8'h7C, 8'h7E, 8'hFF, 8'hFD};
	int errors, checked, cyc, stb_n;
	i2c_host u_host (.sys_clk(sys_clk), .sda_w(sda_h & sda_oe_n), .scl(scl), .sda_h(sda_h), .rd_done(rd_done),
		.rd_byte(rd_byte));
	pmic_status_unlock_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_h & sda_oe_n),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .power_hold_pin(power_hold_pin), .adapter_present(fl[11]),
		.usb_supply_present(fl[10]), .button_input_pin(fl[9]), .buck1_good(fl[8]), .buck2_good(fl[7]),
		.buck3_good(fl[6]), .linear1_good(fl[5]), .linear2_good(fl[4]), .reg3_good(fl[3]), .reg4_good(fl[2]),
		.reg3_is_switch(fl[1]), .reg4_is_switch(fl[0]), .monitor_enable(en), .monitor_route(route),
		.off_state(off), .protected_wr_stb(stb), .protected_addr(pa), .protected_wdata(pd),
		.protected_rdata(prot_rdata));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic hc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : hc
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic wrap_up();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		u_host.wr(a, v, ok);
		check("ack", ok, 8'h01);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		u_host.rd(a, 1);
	endtask : rd
	function automatic logic [7:0] st_exp(input logic req);
		return {req, 3'b000, fl[11], fl[10], 1'b0, !fl[9]};
	endfunction : st_exp
	task automatic stb_chk(input int n, input logic [7:0] a, input logic [7:0] v);
		check("strobes", 8'(stb_n), 8'(n));
		check("prot addr", stb_a, a);
		check("prot data", stb_d, v);
	endtask : stb_chk
	always @(posedge sys_clk) begin
		if (rd_done === 1'b1)
			check("read", rd_byte, q.pop_front());
		if (stb === 1'b1) begin
			stb_n++;
			stb_a = pa;
			stb_d = pd;
		end
		cyc++;
		if (cyc == 80000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		rst_n = 1'b0;
		power_hold_pin = 1'b1;
		fl = 12'h200;
		prot_rdata = 8'h00;
		void'($urandom(32'h2acace19));
		hc(16);
		rst_n <= 1'b1;
		hc(4);
		for (int a = 9; a < 13; a++)
			rd(8'(a), 8'h00);
		for (int c = 0; c < 8; c++) begin
			r = 8'($urandom());
			wr(8'h09, {r[4:0], 3'(c)});
			hc(4);
			check("enable", en, 8'(c > 0 && c < 6));
			check("route", route, 8'((c > 0 && c < 6) ? 1 << (c - 1) : 0));
			rd(8'h09, {r[4:0], 3'(c)});
		end
		for (int i = 0; i < 4; i++) begin
			fl <= 12'($urandom());
			wr(8'h0C, 8'hFF);
			wr(8'h0A, 8'h7F);
			rd(8'h0A, st_exp(1'b0));
			rd(8'h0C, {1'b0, fl[3] | fl[1], fl[2] | fl[0], fl[8:4]});
		end
		prot_rdata <= 8'($urandom());
		hc(1);
		rd(8'h0E, prot_rdata);
		wr(8'h05, 8'hA5);
		foreach (bad[i]) begin
			wr(8'h0B, bad[i]);
			wr(8'h0D, 8'($urandom()));
			stb_chk(0, 8'h00, 8'h00);
		end
		d = 8'($urandom());
		wr(8'h0B, unlock_key_value);
		wr(8'h0D, d);
		stb_chk(1, 8'h0D, d);
		wr(8'h0D, ~d);
		rd(8'h0B, 8'h00);
		wr(8'h0B, unlock_key_value);
		wr(8'h09, 8'h00);
		wr(8'h0F, ~d);
		stb_chk(1, 8'h0D, d);
		wr(8'h0B, unlock_key_value);
		wr(8'h0F, ~d);
		stb_chk(2, 8'h0F, ~d);
		wr(8'h0A, 8'h80);
		rd(8'h0A, st_exp(1'b1));
		check("off", off, 8'h00);
		power_hold_pin <= 1'b0;
		hc(8);
		check("off", off, 8'h01);
		rd(8'h0A, st_exp(1'b0));
		rst_n <= 1'b0;
		hc(16);
		rst_n <= 1'b1;
		power_hold_pin <= 1'b1;
		hc(4);
		check("off", off, 8'h00);
		rd(8'h09, 8'h00);
		rd(8'h0B, 8'h00);
		q.push_back(8'h00);
		q.push_back(st_exp(1'b0));
		q.push_back(8'h00);
		u_host.rd(8'h09, 3);
		check("sda out", sda_out, 8'h00);
		wrap_up();
	end
endmodule : tb
